/* File: verilog/erd_pkg.sv */
// What this block does
// RULE1 - set status bit 2 when frame ends on odd nibble, nibble mode only
// RULE2 - set status bit 1 on crc failure, only in the last descriptor
// RULE3 - status bit 0 marks extended status when timestamp or full offload built in
// RULE4 - with full offload, extended status bit set even when checksum engine skips
// RULE5 - without those features, bit 0 means address slot 1..15 matched, 0 for slot 0
// RULE6 - control bit 31 suppresses receive-complete irq flag for that frame
// RULE7 - ring end flag sends next fetch back to list base
// RULE8 - chained flag makes word 3 next-descriptor address, second size ignored
// RULE9 - ring end flag wins over chained flag
// RULE10 - software gives first buffer size in bytes, multiple of four
// RULE11 - zero first buffer size skips buffer one
// RULE12 - word 2 is the full 32-bit first buffer address
// RULE13 - word 3 is the full 32-bit next descriptor address when chained
// RULE14 - set status bit 8 in descriptor holding the last buffers of frame
// RULE15 - reserved control fields are ignored by the device
package erd_pkg;
	localparam logic [4:0] STS_DRIBBLE_BIT = 5'd2;
	localparam logic [4:0] STS_CRC_BIT = 5'd1;
	localparam logic [4:0] STS_EXT_BIT = 5'd0;
	localparam logic [4:0] STS_LAST_BIT = 5'd8;
	localparam logic [4:0] STS_SUMMARY_BIT = 5'd30;
	localparam logic [4:0] CTL_IRQ_OFF_BIT = 5'd31;
	localparam logic [4:0] CTL_RING_END_BIT = 5'd15;
	localparam logic [4:0] CTL_CHAINED_BIT = 5'd14;
	localparam logic [4:0] CTL_SIZE1_MSB = 5'd12;
	localparam logic [4:0] CTL_SIZE2_LSB = 5'd16;
	localparam logic [4:0] CTL_SIZE2_MSB = 5'd28;
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
	localparam logic [31:0] WORD3_OFS = 32'h0000_000c;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BASE = 8'h04;
	localparam logic [7:0] REG_CUR = 8'h08;
	localparam logic [7:0] REG_IRQ_STS = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [7:0] REG_W0 = 8'h14;
	localparam logic [7:0] REG_W1 = 8'h18;
	localparam logic [7:0] REG_W2 = 8'h1c;
	localparam logic [7:0] REG_W3 = 8'h20;
	localparam logic [7:0] REG_STATUS_OUT = 8'h24;
	localparam logic [7:0] REG_NEXT = 8'h28;
	localparam logic [7:0] REG_BUF = 8'h2c;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// irq status bit positions
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_DESC_DONE = 1;
	localparam int IRQ_W = 2;

	typedef struct packed {
		logic crc_err;
		logic dribble;
		logic ext_avail;
		logic addr_hi_match;
		logic last;
	} erd_frame_t;

	typedef struct packed {
		logic [31:0] next_addr;
		logic [31:0] buf1_addr;
		logic [12:0] buf1_len;
		logic use_buf1;
		logic irq_off;
	} erd_plan_t;
endpackage

/* File: verilog/erd_desc_decode.sv */
`timescale 1ns/1ps
// decodes one receive descriptor into addresses and flags
module erd_desc_decode
	import erd_pkg::*;
(
	input wire logic [31:0] cur_addr_i,
	input wire logic [31:0] base_addr_i,
	input wire logic [31:0] ctl_word_i,
	input wire logic [31:0] buf_word_i,
	input wire logic [31:0] nxt_word_i,
	output erd_plan_t plan_o
);
	logic ring_end;
	logic chained;

	// only the documented control bits are looked at; reserved ones fall away
	assign ring_end = ctl_word_i[CTL_RING_END_BIT]; // RULE15
	assign chained = ctl_word_i[CTL_CHAINED_BIT]; // RULE8

	// next descriptor choice: ring end first, then chain, else contiguous
	always_comb begin
		plan_o.irq_off = ctl_word_i[CTL_IRQ_OFF_BIT]; // RULE6
		plan_o.buf1_len = ctl_word_i[CTL_SIZE1_MSB:0]; // RULE10
		plan_o.use_buf1 = (ctl_word_i[CTL_SIZE1_MSB:0] != 13'h0000); // RULE11
		plan_o.buf1_addr = buf_word_i; // RULE12
		if (ring_end) begin
			plan_o.next_addr = base_addr_i; // RULE7 RULE9
		end else if (chained) begin
			plan_o.next_addr = nxt_word_i; // RULE13 RULE8
		end else begin
			plan_o.next_addr = cur_addr_i + DESC_STRIDE;
		end
	end
endmodule // erd_desc_decode

/* File: verilog/erd_rx_desc.sv */
`timescale 1ns/1ps
// receive descriptor handler with axi4-lite register access
module erd_rx_desc
	import erd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// frame end event from the mac, same clock
	input wire logic frame_end_i,
	input wire logic frame_crc_err_i,
	input wire logic frame_odd_nibble_i,
	input wire logic frame_addr_hi_i,
	input wire logic frame_csum_done_i,
	input wire logic frame_summary_err_i,
	// axi4-lite slave
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	output logic irq_o,
	output logic [31:0] next_desc_addr_o,
	output logic [31:0] buf1_addr_o,
	output logic [12:0] buf1_len_o,
	output logic buf1_use_o
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] base;
		logic [31:0] cur;
		logic [IRQ_W-1:0] irq_sts;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		logic [31:0] w3;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic [31:0] next_out;
		logic [31:0] buf_out;
		logic [12:0] len_out;
		logic use_out;
		logic awready;
		logic wready;
		logic arready;
	} erd_state_t;

	erd_state_t s_q;
	erd_state_t s_d;
	erd_plan_t plan;
	erd_frame_t fr;
	logic ts_built;
	logic full_offload;
	logic nibble_mode;
	logic do_write;
	logic [31:0] wmerged;
	logic [31:0] status_word;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;

	erd_desc_decode u_dec (
		.cur_addr_i(s_q.cur),
		.base_addr_i(s_q.base),
		.ctl_word_i(s_q.w1),
		.buf_word_i(s_q.w2),
		.nxt_word_i(s_q.w3),
		.plan_o(plan)
	);

	// configuration bits of the control register
	assign ts_built = s_q.ctrl[0];
	assign full_offload = s_q.ctrl[1];
	assign nibble_mode = s_q.ctrl[2];

	// frame status capture; this handler always closes a frame in the current descriptor
	always_comb begin
		fr.last = frame_end_i; // RULE14
		fr.crc_err = fr.last & frame_crc_err_i; // RULE2
		fr.dribble = nibble_mode & frame_odd_nibble_i; // RULE1
		fr.ext_avail = fr.last & ~frame_summary_err_i
			& (ts_built | (full_offload & (frame_csum_done_i | 1'b1))); // RULE3 RULE4
		fr.addr_hi_match = frame_addr_hi_i; // RULE5
	end

	// the written-back status word
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[STS_LAST_BIT] = fr.last; // RULE14
		status_word[STS_CRC_BIT] = fr.crc_err; // RULE2
		status_word[STS_DRIBBLE_BIT] = fr.dribble; // RULE1
		status_word[STS_SUMMARY_BIT] = fr.last & frame_summary_err_i;
		if (ts_built | full_offload) begin
			status_word[STS_EXT_BIT] = fr.ext_avail; // RULE3
		end else begin
			status_word[STS_EXT_BIT] = fr.addr_hi_match; // RULE5
		end
	end

	// byte-lane merge of write data
	always_comb begin
		wmerged = rd_val;
		for (int i = 0; i < 4; i++) begin
			if (s_q.w_strb[i]) begin
				wmerged[i*8 +: 8] = s_q.w_data[i*8 +: 8];
			end
		end
	end

	// register read mux, also used for byte merge on writes
	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_q.rvalid ? s_q.aw_addr : (s_q.aw_got ? s_q.aw_addr : s_araddr_i))
			REG_CTRL: rd_val = s_q.ctrl;
			REG_BASE: rd_val = s_q.base;
			REG_CUR: rd_val = s_q.cur;
			REG_IRQ_STS: rd_val = {{(32-IRQ_W){1'b0}}, s_q.irq_sts};
			REG_IRQ_MASK: rd_val = {{(32-IRQ_W){1'b0}}, s_q.irq_mask};
			REG_W0: rd_val = s_q.w0;
			REG_W1: rd_val = s_q.w1;
			REG_W2: rd_val = s_q.w2;
			REG_W3: rd_val = s_q.w3;
			REG_STATUS_OUT: rd_val = status_word;
			REG_NEXT: rd_val = plan.next_addr;
			REG_BUF: rd_val = plan.buf1_addr;
			default: rd_ok = 1'b0;
		endcase
	end

	assign do_write = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
	assign wr_ok = rd_ok & (s_q.aw_addr != REG_STATUS_OUT) & (s_q.aw_addr != REG_NEXT)
		& (s_q.aw_addr != REG_BUF);

	// next-state logic
	always_comb begin
		s_d = s_q;
		// write channels taken in either order
		if (s_awvalid_i & ~s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_awaddr_i;
		end
		if (s_wvalid_i & ~s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_wdata_i;
			s_d.w_strb = s_wstrb_i;
		end
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
			case (s_q.aw_addr)
				REG_CTRL: s_d.ctrl = wmerged;
				REG_BASE: s_d.base = wmerged;
				REG_CUR: s_d.cur = wmerged;
				REG_IRQ_STS: s_d.irq_sts = s_q.irq_sts & ~wmerged[IRQ_W-1:0];
				REG_IRQ_MASK: s_d.irq_mask = wmerged[IRQ_W-1:0];
				REG_W0: s_d.w0 = wmerged;
				REG_W1: s_d.w1 = wmerged;
				REG_W2: s_d.w2 = wmerged;
				REG_W3: s_d.w3 = wmerged;
				default: s_d.bresp = RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid & s_bready_i) begin
			s_d.bvalid = 1'b0;
		end
		// read: taken only when no write address is pending, so the mux is free
		if (s_arvalid_i & ~s_q.rvalid & ~s_q.aw_got) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_val;
			s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_q.rvalid & s_rready_i) begin
			s_d.rvalid = 1'b0;
		end
		// frame close: write back status, advance to next descriptor, raise events
		if (frame_end_i) begin
			s_d.w0 = status_word;
			s_d.cur = plan.next_addr; // RULE7 RULE8 RULE9
			s_d.irq_sts[IRQ_DESC_DONE] = 1'b1;
			if (!plan.irq_off) begin
				s_d.irq_sts[IRQ_RX_DONE] = 1'b1; // RULE6
			end
		end
		s_d.irq = |(s_d.irq_sts & s_d.irq_mask);
		s_d.next_out = plan.next_addr;
		s_d.buf_out = plan.buf1_addr; // RULE12
		s_d.len_out = plan.buf1_len;
		s_d.use_out = plan.use_buf1; // RULE11
		// ready flags are registered so the bus outputs leave flip-flops directly
		s_d.awready = ~s_d.aw_got;
		s_d.wready = ~s_d.w_got;
		s_d.arready = ~s_d.rvalid & ~s_d.aw_got;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RESET;
			s_q.irq_mask <= MASK_RESET[IRQ_W-1:0];
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign s_awready_o = s_q.awready;
	assign s_wready_o = s_q.wready;
	assign s_bvalid_o = s_q.bvalid;
	assign s_bresp_o = s_q.bresp;
	assign s_arready_o = s_q.arready;
	assign s_rvalid_o = s_q.rvalid;
	assign s_rdata_o = s_q.rdata;
	assign s_rresp_o = s_q.rresp;
	assign irq_o = s_q.irq;
	assign next_desc_addr_o = s_q.next_out;
	assign buf1_addr_o = s_q.buf_out;
	assign buf1_len_o = s_q.len_out;
	assign buf1_use_o = s_q.use_out;
endmodule // erd_rx_desc

/* File: verification/erd_rx_desc_sva.sv */
`timescale 1ns/1ps
// port-level checks of the register bus and buffer decode
module erd_rx_desc_sva
	import erd_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic s_awvalid_i,
	input wire logic s_awready_o,
	input wire logic s_wvalid_i,
	input wire logic s_wready_o,
	input wire logic [1:0] s_bresp_o,
	input wire logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic s_arvalid_i,
	input wire logic s_arready_o,
	input wire logic [31:0] s_rdata_o,
	input wire logic s_rvalid_o,
	input wire logic s_rready_i,
	input wire logic irq_o,
	input wire logic [12:0] buf1_len_o,
	input wire logic buf1_use_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !s_bvalid_o && !s_rvalid_o)
		else $error("outputs not idle after reset");
	chk_wr_answer: assert property (s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o
		|-> ##2 s_bvalid_o) else $error("write response late");
	chk_wr_stands: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
		else $error("write response dropped");
	chk_wr_done: assert property (s_bvalid_o && s_bready_i |=> !s_bvalid_o)
		else $error("write response repeated");
	chk_rd_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
		else $error("read response late");
	chk_rd_stands: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
		else $error("read data dropped");
	chk_rd_single: assert property (s_rvalid_o |-> !s_arready_o)
		else $error("read accepted while one pending");
	chk_rd_done: assert property (s_rvalid_o && s_rready_i |=> !s_rvalid_o)
		else $error("read response repeated");
	chk_buf_skip: assert property (buf1_use_o == (buf1_len_o != 13'h0000))
		else $error("buffer use disagrees with size");
endmodule // erd_rx_desc_sva

bind erd_rx_desc erd_rx_desc_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .s_awvalid_i(s_awvalid_i),
	.s_awready_o(s_awready_o), .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
	.s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
	.s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
	.s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .irq_o(irq_o),
	.buf1_len_o(buf1_len_o), .buf1_use_o(buf1_use_o));

/* File: verification/erd_host_list.sv */
`timescale 1ns/1ps
// host-owned receive descriptor list, four entries
module erd_host_list
	import erd_pkg::*;
(
	input wire logic [1:0] idx_i,
	output logic [31:0] ctl_o,
	output logic [31:0] buf_o,
	output logic [31:0] nxt_o
);
	// sizes are byte counts in multiples of four; entry 1 dirties reserved fields on purpose
	always_comb begin
		case (idx_i)
			2'h0: ctl_o = 32'h0000_0040;
			2'h1: ctl_o = 32'h6abc_6080;
			2'h2: ctl_o = 32'h0000_8100;
			default: ctl_o = 32'h0000_c000;
		endcase
	end
	// buffer pointers need not be aligned
	assign buf_o = 32'h8765_4321 ^ {30'h0, idx_i};
	assign nxt_o = 32'hf000_0ff0 + {28'h0, idx_i, 2'h0};
endmodule // erd_host_list

/* File: verification/test_erd_rx_desc.sv */
`timescale 1ns/1ps
// bench for the receive descriptor handler
module test_erd_rx_desc;
	import erd_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic fe = 1'b0;
	logic [4:0] fq = 5'h00;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd_v, ex;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [1:0] idx = 2'h0;
	logic aw_r, w_r, b_v, ar_r, r_v, irq, use1;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, nda, b1a, ctl, bufw, nxt;
	logic [12:0] b1l;
	logic [2:0] cc [4] = '{3'h4, 3'h0, 3'h2, 3'h1};
	logic [4:0] qq [4] = '{5'h1c, 5'h08, 5'h00, 5'h01};
	int num_errors = 0;
	int compares = 0;
	erd_host_list u_host (.idx_i(idx), .ctl_o(ctl), .buf_o(bufw), .nxt_o(nxt));
	erd_rx_desc u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .frame_end_i(fe),
		.frame_crc_err_i(fq[4]), .frame_odd_nibble_i(fq[3]), .frame_addr_hi_i(fq[2]),
		.frame_csum_done_i(fq[1]), .frame_summary_err_i(fq[0]), .s_awaddr_i(awa),
		.s_awvalid_i(awv), .s_awready_o(aw_r), .s_wdata_i(wd), .s_wstrb_i(4'hf),
		.s_wvalid_i(wv), .s_wready_o(w_r), .s_bresp_o(bresp), .s_bvalid_o(b_v),
		.s_bready_i(br), .s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(ar_r),
		.s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(r_v), .s_rready_i(rr),
		.irq_o(irq), .next_desc_addr_o(nda), .buf1_addr_o(b1a), .buf1_len_o(b1l),
		.buf1_use_o(use1));
	// clock generator
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	task chk(input logic [31:0] e, input logic [31:0] g, input string n);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// one axi4-lite write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		// an edge between transfers, so no handshake signal is assigned twice at once
		@(posedge clk_i);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk_i);
			if (aw_r) awv <= 1'b0;
			if (w_r) wv <= 1'b0;
		end while (!b_v);
		br <= 1'b0;
		chk({30'h0, er}, {30'h0, bresp}, "bresp");
	endtask
	// one axi4-lite read
	task rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk_i);
			if (ar_r) arv <= 1'b0;
		end while (!r_v);
		rr <= 1'b0;
		rd_v = rdata;
		chk({30'h0, er}, {30'h0, rresp}, "rresp");
	endtask
	// single-cycle frame end with qualifiers {crc, odd, addr_hi, csum_done, summary}
	task frame(input logic [4:0] q);
		fe <= 1'b1;
		fq <= q;
		@(posedge clk_i);
		fe <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	// expected status bits 30, 8 and 2..0 for a ctrl setting and frame qualifiers
	function automatic logic [31:0] sts(input logic [2:0] c, input logic [4:0] q);
		logic e;
		e = (c[1:0] != 2'b00) ? !q[0] : q[2];
		return (32'(q[0]) << 30) | 32'h100 | (32'(q[4]) << 1) | (32'(q[3] & c[2]) << 2) | 32'(e);
	endfunction
	task end_of_test;
		if (num_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(REG_CTRL, RESP_OKAY);
		chk(CTRL_RESET, rd_v, "ctrl reset");
		rd(REG_IRQ_MASK, RESP_OKAY);
		chk(MASK_RESET, rd_v, "mask reset");
		rd(8'hfc, RESP_SLVERR);
		wr(REG_NEXT, 32'h0000_0001, RESP_SLVERR);
		wr(REG_BASE, 32'h0000_1000, RESP_OKAY);
		// walk every descriptor of the host list
		for (int i = 0; i < 4; i++) begin
			idx <= 2'(i);
			@(posedge clk_i);
			wr(REG_CUR, 32'h0000_1040, RESP_OKAY);
			wr(REG_W1, ctl, RESP_OKAY);
			wr(REG_W2, bufw, RESP_OKAY);
			wr(REG_W3, nxt, RESP_OKAY);
			ex = ctl[15] ? 32'h0000_1000 : (ctl[14] ? nxt : 32'h0000_1050);
			@(negedge clk_i);
			chk(ex, nda, "next addr");
			chk(bufw, b1a, "buf1 addr");
			chk({19'h0, ctl[12:0]}, {19'h0, b1l}, "buf1 len");
			chk({31'h0, ctl[12:0] != 13'h0}, {31'h0, use1}, "buf1 use");
			@(posedge clk_i);
		end
		wr(REG_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
		// status encodings per feature setting, interrupt raise and clear
		for (int j = 0; j < 4; j++) begin
			wr(REG_CTRL, {29'h0, cc[j]}, RESP_OKAY);
			frame(qq[j]);
			rd(REG_W0, RESP_OKAY);
			chk(sts(cc[j], qq[j]), rd_v & 32'h4000_0107, "status");
			chk(32'h1, {31'h0, irq}, "irq set");
			wr(REG_IRQ_STS, 32'h0000_0003, RESP_OKAY);
			@(negedge clk_i);
			chk(32'h0, {31'h0, irq}, "irq clear");
			@(posedge clk_i);
		end
		// suppressed receive-complete flag
		wr(REG_W1, 32'h8000_0040, RESP_OKAY);
		frame(5'h00);
		rd(REG_IRQ_STS, RESP_OKAY);
		chk(32'h0, rd_v & 32'h1, "rx done suppressed");
		chk(32'h0, {31'h0, irq}, "irq suppressed");
		// clock enable low freezes state: a frame end must leave no trace
		wr(REG_IRQ_STS, 32'h0000_0003, RESP_OKAY);
		ce_i <= 1'b0;
		frame(5'h00);
		ce_i <= 1'b1;
		rd(REG_IRQ_STS, RESP_OKAY);
		chk(32'h0, rd_v, "frozen irq status");
		end_of_test();
	end
endmodule // test_erd_rx_desc
